// >>> design/whs_pkg.sv
/*
  Constants, register map and state codes for the waveform hop sequencer.
  Assumes a 10 MHz pclk and an APB master with 32-bit data and byte addresses.
*/
// Operation
// - Sixteen step set-ups, indices 0 to 15, each always valid, defaults after reset.
// - Running starts at step 0, steps up to the last index, then wraps.
// - Shape, frequency, amplitude, offset per step; symmetry and impedance global.
// - Each step holds its own advance mode and interval; modes may be mixed.
// - Internal interval programmable from 2 ms to 65 s in 1 ms steps.
// - Interval code 1 selects external trigger, code 0 selects manual advance.
// - External mode advances on each rising edge of the trigger input.
// - Manual mode advances once per step key press or remote step command.
// - Sync goes low at step entry, high once frequency and shape have settled.
// - Sync may rise before amplitude settles, but not before attenuator re-enable.
// - An attenuator change disables the output for 45 ms.
// - Settling takes 0.5 ms frequency only, 3 ms with shape, 40 ms amplitude.
// - Sync falls about 1 ms after the qualifying external trigger edge.
// - Step duration is timed from the sync rising edge.
// - Run control toggles between running and off; editing blocked while running.
// - Leaving hop forces run off and restores the pre-hop generator set-up.
// - Display tracks only manual steps or steps longer than 500 ms.
// - Holding escape about one second forces an exit from hop.
// - Hop set-up saved at power-down, untouched by stores and default reload.
// - Copy duplicates the preceding step's parameters into the selected step.
package whs_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int STEPS = 16;
  localparam int IDX_W = 4;
  localparam int SHP_W = 3;
  localparam int FRQ_W = 32;
  localparam int LVL_W = 16;
  localparam int ITV_W = 17;
  localparam int SYM_W = 8;
  localparam int TMR_W = 18;
  localparam int ADR_W = 8;

  // ----------------------------------------------------------------------
  // Register byte addresses and control bits
  // ----------------------------------------------------------------------
  localparam logic [ADR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] A_LAST = 8'h04;
  localparam logic [ADR_W-1:0] A_SEL = 8'h08;
  localparam logic [ADR_W-1:0] A_SHAPE = 8'h0c;
  localparam logic [ADR_W-1:0] A_FREQ = 8'h10;
  localparam logic [ADR_W-1:0] A_AMPL = 8'h14;
  localparam logic [ADR_W-1:0] A_OFFS = 8'h18;
  localparam logic [ADR_W-1:0] A_INTV = 8'h1c;
  localparam logic [ADR_W-1:0] A_GLOB = 8'h20;
  localparam logic [ADR_W-1:0] A_STAT = 8'h24;
  localparam logic [ADR_W-1:0] A_MSHP = 8'h28;
  localparam logic [ADR_W-1:0] A_MFRQ = 8'h2c;
  localparam logic [ADR_W-1:0] A_MAMP = 8'h30;
  localparam logic [ADR_W-1:0] A_MOFS = 8'h34;
  localparam int CB_RUN = 0;
  localparam int CB_HOP = 1;
  localparam int CB_MAN = 2;
  localparam int CB_COPY = 3;
  localparam int GB_IMP = 8;

  // ----------------------------------------------------------------------
  // Reset values and interval codes
  // ----------------------------------------------------------------------
  localparam logic [SHP_W-1:0] RV_SHAPE = 3'h0;
  localparam logic [FRQ_W-1:0] RV_FREQ = 32'h00989680;
  localparam logic [LVL_W-1:0] RV_AMPL = 16'h00c8;
  localparam logic [LVL_W-1:0] RV_OFFS = 16'h0000;
  localparam logic [ITV_W-1:0] RV_INTV = 17'h003e8;
  localparam logic [IDX_W-1:0] RV_LAST = 4'h1;
  localparam logic [SYM_W-1:0] RV_SYM = 8'h32;
  localparam logic [ITV_W-1:0] ITV_MAN = 17'h00000;
  localparam logic [ITV_W-1:0] ITV_EXT = 17'h00001;
  localparam logic [ITV_W-1:0] ITV_MIN = 17'h00002;
  localparam logic [ITV_W-1:0] ITV_MAX = 17'h0fde8;
  localparam logic [ITV_W-1:0] ITV_DISP = 17'h001f4;
  localparam logic [LVL_W-1:0] ATTN_LVL = 16'h0032;

  // ----------------------------------------------------------------------
  // Timing: microseconds, then counts of 0.5 ms ticks rounded up
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int TICK_US = 500;
  localparam int T_FREQ_US = 500;
  localparam int T_SHAPE_US = 3000;
  localparam int T_TRIG_US = 1000;
  localparam int T_AMP_US = 40000;
  localparam int T_ATTN_US = 45000;
  localparam int T_ESC_US = 1000000;
  localparam int TK_PER_MS = 1000 / TICK_US;
  localparam logic [TMR_W-1:0] TK_FREQ = TMR_W'((T_FREQ_US + TICK_US - 1) / TICK_US);
  localparam logic [TMR_W-1:0] TK_SHAPE = TMR_W'((T_SHAPE_US + TICK_US - 1) / TICK_US);
  localparam logic [TMR_W-1:0] TK_TRIG = TMR_W'((T_TRIG_US + TICK_US - 1) / TICK_US);
  localparam logic [TMR_W-1:0] TK_AMP = TMR_W'((T_AMP_US + TICK_US - 1) / TICK_US);
  localparam logic [TMR_W-1:0] TK_ATTN = TMR_W'((T_ATTN_US + TICK_US - 1) / TICK_US);
  localparam logic [TMR_W-1:0] TK_ESC = TMR_W'(T_ESC_US / TICK_US);
  localparam logic [TMR_W-1:0] TMR_ONE = 18'h00001;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_OFF = 4'b0001,
    S_SETTLE = 4'b0010,
    S_DWELL = 4'b0100,
    S_TRIG = 4'b1000
  } whs_state_e;

endpackage : whs_pkg

// >>> design/whs_tmr_if.sv
/*
  Carrier between the sequencer and one of its tick timers.
  Assumes the sequencer supplies a one-cycle tick every 0.5 ms.
*/
`timescale 1ns/1ps
`default_nettype none
interface whs_tmr_if;
  import whs_pkg::*;
  logic tick;
  logic start;
  logic [TMR_W-1:0] load;
  logic busy;
  logic done;
  modport ctl (output tick, output start, output load, input busy, input done);
  modport tmr (input tick, input start, input load, output busy, output done);
endinterface : whs_tmr_if
`default_nettype wire

// >>> design/whs_timer.sv
/*
  Down counter of 0.5 ms ticks with a one-cycle done pulse.
  Assumes load is at least one; a load of zero never finishes.
*/
`timescale 1ns/1ps
`default_nettype none
module whs_timer
  import whs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  whs_tmr_if.tmr t
);
  logic [TMR_W-1:0] cnt_q;
  logic done_q;

  // A restart overrides a count in flight; the first tick may come early by up to one tick.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else if (t.start)
    begin
      cnt_q <= t.load;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= t.tick && (cnt_q == TMR_ONE);
      if (t.tick && (cnt_q != '0))
        cnt_q <= cnt_q - TMR_ONE;
    end
  end

  assign t.busy = (cnt_q != '0);
  assign t.done = done_q;
endmodule : whs_timer
`default_nettype wire

// >>> design/whs_edge.sv
/*
  Rise and fall detector for a group of synchronous inputs.
  Assumes inputs are already synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module whs_edge #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_q;

  // The previous level is held so each edge yields exactly one pulse.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_q <= '0;
    else
      prev_q <= din;
  end

  assign rise = din & ~prev_q;
  assign fall = ~din & prev_q;
endmodule : whs_edge
`default_nettype wire

// >>> design/whs_sequencer.sv
/*
  Waveform hop sequencer: sixteen stored steps, run control, sync pulse,
  settling timers and APB register access.
  Assumes synchronous key and trigger inputs and a zero-wait APB master.
*/
`timescale 1ns/1ps
`default_nettype none
module whs_sequencer
  import whs_pkg::*;
#(
  parameter int TICK_CYC = TICK_US * CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_trigger_input,
  input wire logic manual_step_key,
  input wire logic remote_step,
  input wire logic escape_key,
  input wire logic power_down,
  input wire logic defaults_reload,
  output logic step_sync_output,
  output logic out_enable,
  output logic hop_active,
  output logic nv_save,
  output logic [SHP_W-1:0] wave_shape,
  output logic [FRQ_W-1:0] wave_freq,
  output logic [LVL_W-1:0] wave_ampl,
  output logic [LVL_W-1:0] wave_offs,
  output logic [SYM_W-1:0] wave_sym,
  output logic wave_imp
);
  // ----------------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------------
  logic [SHP_W-1:0] shp_m [STEPS];
  logic [FRQ_W-1:0] frq_m [STEPS];
  logic [LVL_W-1:0] amp_m [STEPS];
  logic [LVL_W-1:0] ofs_m [STEPS];
  logic [ITV_W-1:0] itv_m [STEPS];
  logic [IDX_W-1:0] last_q, sel_q, step_q, disp_q;
  logic [SYM_W-1:0] sym_q;
  logic imp_q, run_q, hop_q, attn_q, sync_q, save_q;
  logic [SHP_W-1:0] cur_shp_q, m_shp_q;
  logic [FRQ_W-1:0] cur_frq_q, m_frq_q;
  logic [LVL_W-1:0] cur_amp_q, cur_ofs_q, m_amp_q, m_ofs_q;
  logic [TMR_W-1:0] esc_cnt_q;
  logic [$clog2(TICK_CYC)-1:0] pre_q;
  logic [31:0] rdata_d;
  whs_state_e state_q, state_d;
  logic wr, rd, ctrl_wr, tick, enter, exit_req, esc_long;
  logic addr_ok, edit_ok;
  logic [IDX_W-1:0] nxt_idx, prv_idx;
  logic [ITV_W-1:0] itv_clip, nxt_itv, cur_itv;
  logic [3:0] rise, fall;
  whs_tmr_if seq_t ();
  whs_tmr_if amp_t ();

  // ----------------------------------------------------------------------
  // Bus strobes and helpers
  // ----------------------------------------------------------------------
  assign wr = psel && penable && pwrite && addr_ok;
  assign rd = psel && penable && !pwrite;
  assign ctrl_wr = wr && (paddr == A_CTRL);
  assign edit_ok = !run_q;
  assign prv_idx = sel_q - 4'h1;
  assign nxt_idx = (step_q == last_q) ? '0 : step_q + 4'h1;
  assign cur_itv = itv_m[step_q];
  assign nxt_itv = itv_m[enter && (state_q == S_OFF) ? '0 : nxt_idx];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Interval writes are clamped so every code below 2 keeps its mode meaning.
  always_comb
  begin
    itv_clip = pwdata[ITV_W-1:0];
    if (pwdata[31:ITV_W] != '0 || itv_clip > ITV_MAX)
      itv_clip = ITV_MAX;
  end

  // ----------------------------------------------------------------------
  // Edge detection and tick prescaler
  // ----------------------------------------------------------------------
  whs_edge #(.W(4)) u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .din({power_down, escape_key, manual_step_key, external_trigger_input}),
    .rise(rise),
    .fall(fall)
  );

  // One tick every 0.5 ms paces all step timing.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= '0;
    else if (pre_q == ($clog2(TICK_CYC))'(TICK_CYC - 1))
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end
  assign tick = (pre_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  assign seq_t.tick = tick;
  assign amp_t.tick = tick;
  assign amp_t.start = enter;
  assign amp_t.load = TK_AMP;

  whs_timer u_seq_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .t(seq_t)
  );

  whs_timer u_amp_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .t(amp_t)
  );

  // ----------------------------------------------------------------------
  // Escape key: short press leaves hop, a long hold forces it
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      esc_cnt_q <= '0;
    else if (!escape_key)
      esc_cnt_q <= '0;
    else if (tick && esc_cnt_q != TK_ESC)
      esc_cnt_q <= esc_cnt_q + TMR_ONE;
  end
  // The hold path needs no cooperation from the step timing, so it works
  // even when steps are too short for a normal stop.
  assign esc_long = escape_key && tick && (esc_cnt_q == TK_ESC - TMR_ONE);
  assign exit_req = hop_q && (esc_long || (fall[2] && esc_cnt_q < TK_ESC)
    || (ctrl_wr && !pwdata[CB_HOP]));

  // ----------------------------------------------------------------------
  // Run control and hop mode
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hop_q <= 1'b0;
      run_q <= 1'b0;
    end
    else if (exit_req)
    begin
      hop_q <= 1'b0;
      run_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      hop_q <= pwdata[CB_HOP];
      if (hop_q && pwdata[CB_RUN])
        run_q <= ~run_q;
    end
  end

  // ----------------------------------------------------------------------
  // Global and selection registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_q <= RV_LAST;
      sel_q <= '0;
      sym_q <= RV_SYM;
      imp_q <= 1'b0;
    end
    else if (wr && edit_ok)
    begin
      if (paddr == A_LAST)
        last_q <= pwdata[IDX_W-1:0];
      else if (paddr == A_SEL)
        sel_q <= pwdata[IDX_W-1:0];
      else if (paddr == A_GLOB)
      begin
        sym_q <= pwdata[SYM_W-1:0];
        imp_q <= pwdata[GB_IMP];
      end
    end
  end

  // Main set-up stays untouched by hop, so leaving hop restores it as it was.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_shp_q <= RV_SHAPE;
      m_frq_q <= RV_FREQ;
      m_amp_q <= RV_AMPL;
      m_ofs_q <= RV_OFFS;
    end
    else if (defaults_reload)
    begin
      m_shp_q <= RV_SHAPE;
      m_frq_q <= RV_FREQ;
      m_amp_q <= RV_AMPL;
      m_ofs_q <= RV_OFFS;
    end
    else if (wr && !hop_q)
    begin
      if (paddr == A_MSHP)
        m_shp_q <= pwdata[SHP_W-1:0];
      else if (paddr == A_MFRQ)
        m_frq_q <= pwdata;
      else if (paddr == A_MAMP)
        m_amp_q <= pwdata[LVL_W-1:0];
      else if (paddr == A_MOFS)
        m_ofs_q <= pwdata[LVL_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Step memory: defaults at reset, untouched by default reload
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < STEPS; i++)
      begin
        shp_m[i] <= RV_SHAPE;
        frq_m[i] <= RV_FREQ;
        amp_m[i] <= RV_AMPL;
        ofs_m[i] <= RV_OFFS;
        itv_m[i] <= RV_INTV;
      end
    end
    else if (wr && edit_ok)
    begin
      if (paddr == A_SHAPE)
        shp_m[sel_q] <= pwdata[SHP_W-1:0];
      else if (paddr == A_FREQ)
        frq_m[sel_q] <= pwdata;
      else if (paddr == A_AMPL)
        amp_m[sel_q] <= pwdata[LVL_W-1:0];
      else if (paddr == A_OFFS)
        ofs_m[sel_q] <= pwdata[LVL_W-1:0];
      else if (paddr == A_INTV)
        itv_m[sel_q] <= itv_clip;
      else if (paddr == A_CTRL && pwdata[CB_COPY])
      begin
        shp_m[sel_q] <= shp_m[prv_idx];
        frq_m[sel_q] <= frq_m[prv_idx];
        amp_m[sel_q] <= amp_m[prv_idx];
        ofs_m[sel_q] <= ofs_m[prv_idx];
        itv_m[sel_q] <= itv_m[prv_idx];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Step state machine
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    enter = 1'b0;
    seq_t.start = 1'b0;
    seq_t.load = TK_FREQ;
    case (state_q)
      S_OFF:
      begin
        if (run_q)
          enter = 1'b1;
      end
      S_SETTLE:
      begin
        if (seq_t.done)
        begin
          state_d = S_DWELL;
          if (cur_itv >= ITV_MIN)
          begin
            seq_t.start = 1'b1;
            seq_t.load = TMR_W'(cur_itv) * TMR_W'(TK_PER_MS);
          end
        end
      end
      S_DWELL:
      begin
        if (cur_itv == ITV_EXT)
        begin
          if (rise[0])
          begin
            state_d = S_TRIG;
            seq_t.start = 1'b1;
            seq_t.load = TK_TRIG;
          end
        end
        else if (cur_itv == ITV_MAN)
          enter = rise[1] || remote_step || (ctrl_wr && pwdata[CB_MAN]);
        else
          enter = seq_t.done;
      end
      S_TRIG:
      begin
        enter = seq_t.done;
      end
      default:
      begin
        state_d = S_OFF;
      end
    endcase
    if (enter)
    begin
      state_d = S_SETTLE;
      seq_t.start = 1'b1;
      // Sync waits for the slowest of frequency, shape and attenuator work.
      if ((amp_m[nxt_sel()] < ATTN_LVL) != (cur_amp_q < ATTN_LVL))
        seq_t.load = TK_ATTN;
      else if (shp_m[nxt_sel()] != cur_shp_q)
        seq_t.load = TK_SHAPE;
      else
        seq_t.load = TK_FREQ;
    end
    if (!run_q)
    begin
      state_d = S_OFF;
      enter = 1'b0;
      seq_t.start = 1'b0;
    end
  end

  // Index of the step about to be entered.
  function automatic logic [IDX_W-1:0] nxt_sel();
    return (state_q == S_OFF) ? '0 : nxt_idx;
  endfunction : nxt_sel

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= S_OFF;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------------
  // Step entry: index, applied set-up, sync and attenuator blanking
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_q <= '0;
      cur_shp_q <= RV_SHAPE;
      cur_frq_q <= RV_FREQ;
      cur_amp_q <= RV_AMPL;
      cur_ofs_q <= RV_OFFS;
      attn_q <= 1'b0;
    end
    else if (enter)
    begin
      step_q <= nxt_sel();
      cur_shp_q <= shp_m[nxt_sel()];
      cur_frq_q <= frq_m[nxt_sel()];
      cur_amp_q <= amp_m[nxt_sel()];
      cur_ofs_q <= ofs_m[nxt_sel()];
      attn_q <= (amp_m[nxt_sel()] < ATTN_LVL) != (cur_amp_q < ATTN_LVL);
    end
    else if (state_d != S_SETTLE)
      attn_q <= 1'b0;
  end

  // Sync is low for the whole settle phase and high otherwise.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q <= 1'b1;
    else
      sync_q <= !(state_d == S_SETTLE);
  end

  // ----------------------------------------------------------------------
  // Display tracking and power-down save
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      disp_q <= '0;
    else if (!run_q)
      disp_q <= sel_q;
    else if (enter && (nxt_itv == ITV_MAN || nxt_itv > ITV_DISP))
      disp_q <= nxt_sel();
  end

  // One save request per power-down; the hop store lies outside the set-up stores.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      save_q <= 1'b0;
    else
      save_q <= rise[3];
  end
  assign nv_save = save_q;

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata_d = '0;
    addr_ok = 1'b1;
    if (paddr == A_CTRL)
      rdata_d = {30'h00000000, hop_q, run_q};
    else if (paddr == A_LAST)
      rdata_d[IDX_W-1:0] = last_q;
    else if (paddr == A_SEL)
      rdata_d[IDX_W-1:0] = sel_q;
    else if (paddr == A_SHAPE)
      rdata_d[SHP_W-1:0] = shp_m[sel_q];
    else if (paddr == A_FREQ)
      rdata_d = frq_m[sel_q];
    else if (paddr == A_AMPL)
      rdata_d[LVL_W-1:0] = amp_m[sel_q];
    else if (paddr == A_OFFS)
      rdata_d[LVL_W-1:0] = ofs_m[sel_q];
    else if (paddr == A_INTV)
      rdata_d[ITV_W-1:0] = itv_m[sel_q];
    else if (paddr == A_GLOB)
      rdata_d[GB_IMP:0] = {imp_q, sym_q};
    else if (paddr == A_STAT)
      rdata_d[10:0] = {amp_t.busy, out_enable, sync_q, disp_q, step_q};
    else if (paddr == A_MSHP)
      rdata_d[SHP_W-1:0] = m_shp_q;
    else if (paddr == A_MFRQ)
      rdata_d = m_frq_q;
    else if (paddr == A_MAMP)
      rdata_d[LVL_W-1:0] = m_amp_q;
    else if (paddr == A_MOFS)
      rdata_d[LVL_W-1:0] = m_ofs_q;
    else
      addr_ok = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rdata_d;
  end

  // ----------------------------------------------------------------------
  // Outputs: hop set-up while in hop mode, else the main set-up
  // ----------------------------------------------------------------------
  assign wave_shape = hop_q ? cur_shp_q : m_shp_q;
  assign wave_freq = hop_q ? cur_frq_q : m_frq_q;
  assign wave_ampl = hop_q ? cur_amp_q : m_amp_q;
  assign wave_offs = hop_q ? cur_ofs_q : m_ofs_q;
  assign wave_sym = sym_q;
  assign wave_imp = imp_q;
  assign step_sync_output = sync_q;
  assign out_enable = !attn_q;
  assign hop_active = hop_q;
endmodule : whs_sequencer
`default_nettype wire

// >>> sim/whs_sequencer_properties.sv
/* Port checker for the hop sequencer.
   Bound to whs_sequencer; TICK_CYC must match the instance. */
`timescale 1ns/1ps
`default_nettype none
module whs_sequencer_properties
  import whs_pkg::*;
#(
  parameter int TICK_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic power_down,
  input wire logic step_sync_output,
  input wire logic out_enable,
  input wire logic nv_save,
  input wire logic [SYM_W-1:0] wave_sym,
  input wire logic wave_imp
);
  // Bounds scale with the tick so a shortened tick keeps them valid.
  localparam int B_MIN = 75 * TICK_CYC;
  localparam int T_MAX = 100 * TICK_CYC;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sync_settle_a: assert property ($fell(step_sync_output) |-> ##[1:T_MAX] step_sync_output)
    else $error("sync low too long");
  sync_enable_a: assert property ($rose(step_sync_output) |-> out_enable)
    else $error("sync rose while blanked");
  blank_len_a: assert property ($fell(out_enable) |-> ##[B_MIN:T_MAX] out_enable)
    else $error("blanking too long");
  blank_hold_a: assert property ($rose(out_enable) |-> !$past(out_enable, B_MIN))
    else $error("blanking too short");
  sym_write_a: assert property (!$stable(wave_sym) |-> $past(psel && penable && pwrite))
    else $error("symmetry changed without write");
  imp_write_a: assert property (!$stable(wave_imp) |-> $past(psel && penable && pwrite))
    else $error("impedance changed without write");
  save_pulse_a: assert property ($rose(power_down) |-> ##[1:3] nv_save)
    else $error("no save at power down");
  save_once_a: assert property (nv_save |=> !nv_save)
    else $error("save pulse too long");
endmodule : whs_sequencer_properties
`default_nettype wire

// >>> sim/whs_trig_source.sv
/* External trigger source model.
   Fire is a one-cycle request from the bench. */
`timescale 1ns/1ps
`default_nettype none
module whs_trig_source (
  input wire logic pclk,
  input wire logic fire,
  output logic trig
);
  int n = 0;
  initial trig = 1'b0;
  // Each request gives one clean rising edge, held three cycles.
  always @(posedge pclk)
  begin
    n <= fire ? 3 : (n > 0 ? n - 1 : 0);
    trig <= fire || n > 1;
  end
endmodule : whs_trig_source
`default_nettype wire

// >>> sim/test_waveform_hop_sequencer.sv
/* Self-checking bench for the hop sequencer.
   Drives APB, keys and the trigger model; TICK_CYC shortened to 4. */
`timescale 1ns/1ps
`default_nettype none
module test_waveform_hop_sequencer import whs_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nvs;
  logic fire = 1'b0, mkey = 1'b0, pdown = 1'b0, pready, pslverr, er, trig, sync, oen, hop, imp;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [SHP_W-1:0] shp;
  logic [FRQ_W-1:0] frq;
  logic [LVL_W-1:0] amp, ofs;
  logic [SYM_W-1:0] sym;
  int n_fail = 0, n_checks = 0, i;
  initial forever #50 pclk = ~pclk;
  whs_sequencer #(.TICK_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_trigger_input(trig), .manual_step_key(mkey),
    .remote_step(1'b0), .escape_key(1'b0), .power_down(pdown), .defaults_reload(pdown),
    .step_sync_output(sync), .out_enable(oen), .hop_active(hop), .nv_save(nvs),
    .wave_shape(shp), .wave_freq(frq), .wave_ampl(amp), .wave_offs(ofs), .wave_sym(sym),
    .wave_imp(imp));
  whs_trig_source src (.pclk(pclk), .fire(fire), .trig(trig));
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  // One APB transfer; read data and error are taken at the accepting edge.
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (i = 1; pready !== 1'b1 && i < 20; i++) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(i < 20, "apb timeout");
    if (i >= 20) test_done;
  endtask : apb
  // Waits, bounded, for a step frequency with a given sync level.
  task wt(input logic [FRQ_W-1:0] f, input logic s);
    for (i = 0; !(frq === f && sync === s) && i < 2000; i++) @(negedge pclk);
    chk(frq === f && sync === s, "step not reached");
    if (i >= 2000) test_done;
  endtask : wt
  task t_reset;
    chk(frq === RV_FREQ && sym === RV_SYM && sync === 1'b1, "reset outputs");
    apb(A_LAST, 1'b0, 32'h0);
    chk(rd === 32'(RV_LAST), "last reset");
    apb(8'hfc, 1'b0, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    apb(A_GLOB, 1'b1, 32'h155);
    pdown <= 1'b1;
    @(negedge pclk);
    chk(sym === 8'h55 && imp === 1'b1, "global set-up");
  endtask : t_reset
  // Step 0 timed 50 ms with attenuator change, step 1 external, step 2 manual.
  task t_program;
    for (int k = 0; k < 3; k++)
    begin
      apb(A_SEL, 1'b1, k);
      apb(A_FREQ, 1'b1, 32'h1000 * (k + 1));
      apb(A_AMPL, 1'b1, k == 0 ? 32'h10 : 32'hc8);
      apb(A_INTV, 1'b1, k == 0 ? 32'd50 : 32'(2 - k));
    end
    apb(A_LAST, 1'b1, 32'h2);
    apb(A_CTRL, 1'b1, 32'h2);
    apb(A_CTRL, 1'b1, 32'h3);
  endtask : t_program
  task t_run;
    wt(32'h1000, 1'b1);
    for (i = 0; frq !== 32'h2000 && i < 1000; i++) @(negedge pclk);
    chk(i >= 392 && i <= 406, "dwell from sync rise");
    wt(32'h2000, 1'b1);
    @(posedge pclk) fire <= 1'b1;
    @(posedge pclk) fire <= 1'b0;
    for (i = 0; sync !== 1'b0 && i < 100; i++) @(negedge pclk);
    chk(i >= 3 && i <= 14, "trigger to sync fall");
    wt(32'h3000, 1'b1);
    @(posedge pclk) fire <= 1'b1;
    @(posedge pclk) fire <= 1'b0;
    repeat (40) @(negedge pclk);
    chk(frq === 32'h3000, "trigger in manual step");
    @(posedge pclk) mkey <= 1'b1;
    @(posedge pclk) mkey <= 1'b0;
    wt(32'h1000, 1'b1);
  endtask : t_run
  task t_stop;
    apb(A_FREQ, 1'b1, 32'hbeef);
    apb(A_CTRL, 1'b1, 32'h3);
    apb(A_FREQ, 1'b0, 32'h0);
    chk(rd === 32'h3000, "edit while running");
    apb(A_SEL, 1'b1, 32'h3);
    apb(A_CTRL, 1'b1, 32'ha);
    apb(A_FREQ, 1'b0, 32'h0);
    chk(rd === 32'h3000, "copy step");
    apb(A_CTRL, 1'b1, 32'h0);
    pdown <= 1'b0;
    @(negedge pclk);
    chk({hop, frq, amp} === {1'b0, RV_FREQ, RV_AMPL}, "exit hop");
  endtask : t_stop
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_program;
    t_run;
    t_stop;
    test_done;
  end
endmodule : test_waveform_hop_sequencer
bind whs_sequencer whs_sequencer_properties #(.TICK_CYC(TICK_CYC)) u_prop (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .power_down(power_down), .step_sync_output(step_sync_output), .out_enable(out_enable),
  .nv_save(nv_save), .wave_sym(wave_sym), .wave_imp(wave_imp));
`default_nettype wire
